// ### inc/ftrd_pkg.sv
package ftrd_pkg;
  // framing bytes
  localparam logic [7:0] FTRD_ESC = 8'h10;
  localparam logic [7:0] FTRD_EOT = 8'h03;
  localparam logic [7:0] FTRD_ID_REPORT = 8'h8F;
  localparam logic [7:0] FTRD_SUB_FIX = 8'h2B;
  localparam logic [7:0] FTRD_SUB_DELAY = 8'h4A;
  localparam logic [7:0] FTRD_SUB_WIDTH = 8'h4F;
  localparam logic [7:0] FTRD_RSVD_VAL = 8'h00;
  // packet lengths: fix report is 88 bytes with 4 framing bytes
  localparam int FTRD_FIX_TOTAL = 88;
  localparam int FTRD_FIX_DATA = FTRD_FIX_TOTAL - 4;
  localparam int FTRD_DELAY_DATA = 16;
  // fix report data offsets
  localparam int FTRD_OFS_RSV1 = 1;
  localparam int FTRD_OFS_RSV2 = 2;
  localparam int FTRD_OFS_WEEK = 3;
  localparam int FTRD_OFS_TOW = 5;
  localparam int FTRD_OFS_LAT = 9;
  localparam int FTRD_OFS_LON = 13;
  localparam int FTRD_OFS_ALT = 17;
  localparam int FTRD_OFS_VE = 21;
  localparam int FTRD_OFS_VN = 25;
  localparam int FTRD_OFS_VU = 29;
  localparam int FTRD_OFS_STAT = 33;
  localparam int FTRD_OFS_HLTH = 34;
  localparam int FTRD_OFS_RSV3 = 35;
  localparam int FTRD_OFS_CHAN = 36;
  localparam int FTRD_CHAN_LEN = 4;
  localparam int FTRD_NUM_CHAN = 12;
  // field limits
  localparam logic [15:0] FTRD_WEEK_MAX = 16'h03FF;
  localparam logic [31:0] FTRD_TOW_MAX = 32'h240C83FF; // 604799999
  localparam logic [7:0] FTRD_SV_GPS_MAX = 8'h20;
  localparam logic [7:0] FTRD_SV_SBAS_MIN = 8'h78;
  localparam logic [7:0] FTRD_SV_SBAS_MAX = 8'h8A;
  localparam logic [7:0] FTRD_SNR_MAX = 8'h37;
  // status codes
  localparam logic [7:0] FTRD_ST_FIXING = 8'h00;
  localparam logic [7:0] FTRD_ST_NOTIME = 8'h01;
  localparam logic [7:0] FTRD_ST_PDOP = 8'h03;
  localparam logic [7:0] FTRD_ST_SV0 = 8'h08;
  localparam logic [7:0] FTRD_ST_SV3 = 8'h0B;
  localparam logic [7:0] FTRD_ST_STILL = 8'hBB;
  // bit positions
  localparam int FTRD_H_ANT = 0;
  localparam int FTRD_H_SHORT = 1;
  localparam int FTRD_H_2D = 2;
  localparam int FTRD_H_CORR = 3;
  localparam int FTRD_MS_ACQ = 2;
  localparam int FTRD_MS_EPH = 4;
  // delay report offsets
  localparam int FTRD_DOFS_POL = 3;
  localparam int FTRD_DOFS_DBL = 4;
  localparam int FTRD_DOFS_END = 11;
  // apb map
  localparam logic [7:0] FTRD_A_CTRL = 8'h00;
  localparam logic [7:0] FTRD_A_STATUS = 8'h04;
  localparam logic [7:0] FTRD_A_WEEK = 8'h08;
  localparam logic [7:0] FTRD_A_TOW = 8'h0C;
  localparam logic [7:0] FTRD_A_LAT = 8'h10;
  localparam logic [7:0] FTRD_A_LON = 8'h14;
  localparam logic [7:0] FTRD_A_ALT = 8'h18;
  localparam logic [7:0] FTRD_A_VE = 8'h1C;
  localparam logic [7:0] FTRD_A_VN = 8'h20;
  localparam logic [7:0] FTRD_A_VU = 8'h24;
  localparam logic [7:0] FTRD_A_FIXST = 8'h28;
  localparam logic [7:0] FTRD_A_DLYLO = 8'h2C;
  localparam logic [7:0] FTRD_A_DLYHI = 8'h30;
  localparam logic [7:0] FTRD_A_CHAN = 8'h40;
  localparam logic [31:0] FTRD_CTRL_RST = 32'h0000_0001;
  typedef enum logic [2:0] {
    FTRD_HUNT, FTRD_GOT_ESC, FTRD_IDB, FTRD_DATA, FTRD_DATA_ESC
  } ftrd_state_t;
endpackage : ftrd_pkg

// ### design/ftrd_destuff.sv
`timescale 1ns/1ps
// collapses doubled escapes, flags frame start and end
module ftrd_destuff
  import ftrd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic in_valid,
  input wire logic [7:0] in_byte,
  output logic sof,
  output logic eof,
  output logic dat_valid,
  output logic [7:0] dat
);
  ftrd_state_t st_r;

  // framing state machine; id byte stands on dat with sof, without dat_valid
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= FTRD_HUNT;
      sof <= 1'b0;
      eof <= 1'b0;
      dat_valid <= 1'b0;
      dat <= 8'h00;
    end else begin
      sof <= 1'b0;
      eof <= 1'b0;
      dat_valid <= 1'b0;
      if (in_valid) begin
        case (st_r)
          FTRD_HUNT: if (in_byte == FTRD_ESC) st_r <= FTRD_GOT_ESC;
          FTRD_GOT_ESC: begin
            if (in_byte != FTRD_ESC && in_byte != FTRD_EOT) begin
              sof <= 1'b1; // [R1]
              dat <= in_byte;
              st_r <= FTRD_DATA;
            end else begin
              st_r <= FTRD_HUNT;
            end
          end
          FTRD_DATA: begin
            if (in_byte == FTRD_ESC) begin
              st_r <= FTRD_DATA_ESC;
            end else begin
              dat_valid <= 1'b1;
              dat <= in_byte;
            end
          end
          FTRD_DATA_ESC: begin
            if (in_byte == FTRD_ESC) begin
              dat_valid <= 1'b1; // [R23]
              dat <= FTRD_ESC;
              st_r <= FTRD_DATA;
            end else if (in_byte == FTRD_EOT) begin
              eof <= 1'b1; // [R1]
              st_r <= FTRD_HUNT;
            end else begin
              // a lone escape mid-packet starts a new frame
              sof <= 1'b1;
              dat <= in_byte;
              st_r <= FTRD_DATA;
            end
          end
          default: st_r <= FTRD_HUNT;
        endcase
      end
    end
  end
endmodule : ftrd_destuff

// ### design/ftrd_top.sv
`timescale 1ns/1ps
// Overview of operation
// [R1] fix report framed: escape, id 0x8F, data, escape end-of-text, 88 bytes
// [R2] first data byte is sub-code 0x2B, selects the fix layout
// [R3] report arrives on request or periodically; both accepted alike
// [R4] data bytes 1, 2 and 35 reserved, sent zero, ignored
// [R5] 16-bit week at offset 3, valid range 0 to 1023
// [R6] 32-bit time of week in ms at offset 5, up to 604799999
// [R7] signed latitude at offset 9 in 2^-31 semicircles
// [R8] unsigned longitude at offset 13 in 2^-31 semicircles
// [R9] host converts to radians and wraps longitude above pi
// [R10] signed altitude in mm at offset 17
// [R11] signed velocities east 21, north 25, up 29, in mm/s
// [R12] status byte at 33 with fixed meanings for listed codes
// [R13] health bit 0 antenna fault, bit 1 short versus open
// [R14] health bits 2 and 3 valid only while status is zero
// [R15] health bits 4 to 7 power-up and clock condition flags
// [R16] twelve 4-byte channel records start at offset 36 plus 4N
// [R17] record holds satellite id and signal strength 0 to 55
// [R18] record status bit 2 acquired, bit 4 ephemeris
// [R19] record byte 4 zero when satellite used in fix
// [R20] delay response is 16 bytes with first byte 0x4A
// [R21] byte 3 polarity, bytes 4 to 11 offset double
// [R22] width report accepted only after a width command
// [R23] doubled escapes collapse to one data byte before counting
// [R24] multi-byte fields arrive most significant byte first
module ftrd_top
  import ftrd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic width_cmd_sent,
  output logic fix_done,
  output logic frame_err
);
  logic sof;
  logic eof;
  logic dv;
  logic [7:0] db;
  logic [6:0] cnt_r;
  logic is_rpt_r;
  logic [7:0] sub_r;
  logic bad_r;
  logic [31:0] sh_r;
  logic [31:0] shn;
  logic [31:0] ctrl_r;
  logic [15:0] week_r;
  logic [31:0] tow_r;
  logic [31:0] lat_r;
  logic [31:0] lon_r;
  logic [31:0] alt_r;
  logic [31:0] ve_r;
  logic [31:0] vn_r;
  logic [31:0] vu_r;
  logic [7:0] stat_r;
  logic [7:0] hlth_r;
  logic [31:0] chan_r [FTRD_NUM_CHAN];
  logic [31:0] chan_tmp_r [FTRD_NUM_CHAN];
  logic [31:0] tmp_r [10];
  logic [15:0] week_tmp_r;
  logic [7:0] stat_tmp_r;
  logic [7:0] hlth_tmp_r;
  logic [7:0] pol_r;
  logic [7:0] pol_tmp_r;
  logic [63:0] dly_r;
  logic [63:0] dly_tmp_r;
  logic width_arm_r;
  logic [7:0] width_cnt_r;
  logic [7:0] range_err_r;
  logic [7:0] rerr_tmp_r;
  logic [7:0] fix_cnt_r;
  logic [7:0] dly_cnt_r;
  logic fix_ok;
  logic dly_ok;
  logic wid_ok;
  logic [3:0] ch_idx;
  logic [1:0] ch_pos;
  logic [6:0] rel;

  ftrd_destuff u_destuff (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(rx_valid),
    .in_byte(rx_byte),
    .sof(sof),
    .eof(eof),
    .dat_valid(dv),
    .dat(db)
  );

  ////////////////////////////////////////////////////////////////////////////
  // byte counting; cnt counts data bytes after the id byte
  // offsets count collapsed bytes, so a stuffed escape never shifts a
  // field further down the packet
  assign shn = {sh_r[23:0], db}; // [R24]
  assign rel = cnt_r - 7'(FTRD_OFS_CHAN);
  assign ch_idx = rel[5:2];
  assign ch_pos = rel[1:0];
  // frame complete only with exact length and matching sub-code
  assign fix_ok = eof && !bad_r && is_rpt_r && sub_r == FTRD_SUB_FIX
    && cnt_r == 7'(FTRD_FIX_DATA); // [R1] [R2]
  assign dly_ok = eof && !bad_r && is_rpt_r && sub_r == FTRD_SUB_DELAY
    && cnt_r == 7'(FTRD_DELAY_DATA); // [R20]
  // width length is not judged here; its layout belongs to the command
  assign wid_ok = eof && !bad_r && is_rpt_r
    && sub_r == FTRD_SUB_WIDTH && width_arm_r; // [R22]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 7'h00;
      is_rpt_r <= 1'b0;
      sub_r <= 8'h00;
      bad_r <= 1'b0;
      sh_r <= 32'h0000_0000;
    end else if (sof) begin
      is_rpt_r <= (db == FTRD_ID_REPORT); // [R1]
      cnt_r <= 7'h00;
      bad_r <= 1'b0;
      sub_r <= 8'h00;
    end else if (dv) begin
      if (cnt_r == 7'h00) begin
        sub_r <= db; // [R2]
      end
      sh_r <= shn;
      // saturate instead of wrapping, so a runaway frame can never
      // alias back onto a legal length and commit garbage
      if (cnt_r == 7'h7F) begin
        bad_r <= 1'b1; // overrun, frame too long
      end else begin
        cnt_r <= cnt_r + 7'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // field capture into shadows; committed only on a good frame so a
  // torn packet never mixes with the last good fix
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      week_tmp_r <= 16'h0000;
      stat_tmp_r <= 8'h00;
      hlth_tmp_r <= 8'h00;
      rerr_tmp_r <= 8'h00;
      for (int i = 0; i < 10; i++) begin
        tmp_r[i] <= 32'h0000_0000;
      end
      for (int i = 0; i < FTRD_NUM_CHAN; i++) begin
        chan_tmp_r[i] <= 32'h0000_0000;
      end
    end else if (sof) begin
      rerr_tmp_r <= 8'h00;
    end else if (dv && is_rpt_r && sub_r == FTRD_SUB_FIX) begin
      case (int'(cnt_r))
        FTRD_OFS_RSV1, FTRD_OFS_RSV2, FTRD_OFS_RSV3: ; // [R4]
        FTRD_OFS_WEEK + 1: begin
          week_tmp_r <= shn[15:0]; // [R5]
          rerr_tmp_r[0] <= (shn[15:0] > FTRD_WEEK_MAX);
        end
        FTRD_OFS_TOW + 3: begin
          tmp_r[0] <= shn; // [R6]
          rerr_tmp_r[1] <= (shn > FTRD_TOW_MAX);
        end
        FTRD_OFS_LAT + 3: tmp_r[1] <= shn; // [R7]
        FTRD_OFS_LON + 3: tmp_r[2] <= shn; // [R8]
        FTRD_OFS_ALT + 3: tmp_r[3] <= shn; // [R10]
        FTRD_OFS_VE + 3: tmp_r[4] <= shn; // [R11]
        FTRD_OFS_VN + 3: tmp_r[5] <= shn; // [R11]
        FTRD_OFS_VU + 3: tmp_r[6] <= shn; // [R11]
        FTRD_OFS_STAT: stat_tmp_r <= db; // [R12]
        FTRD_OFS_HLTH: hlth_tmp_r <= db; // [R13] [R15]
        default: begin
          if (cnt_r >= 7'(FTRD_OFS_CHAN) && cnt_r < 7'(FTRD_FIX_DATA)
              && ch_pos == 2'd3) begin
            chan_tmp_r[ch_idx] <= shn; // [R16]
            // [R17] id must be 1..32 or 120..138, strength up to 55
            if (!((shn[31:24] != 8'h00 && shn[31:24] <= FTRD_SV_GPS_MAX)
                || (shn[31:24] >= FTRD_SV_SBAS_MIN
                && shn[31:24] <= FTRD_SV_SBAS_MAX))
                || shn[23:16] > FTRD_SNR_MAX) begin
              rerr_tmp_r[2] <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  // delay response capture
  // only the polarity byte and the double are kept; the reserved tail is never stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pol_tmp_r <= 8'h00;
      dly_tmp_r <= 64'h0;
    end else if (dv && is_rpt_r && sub_r == FTRD_SUB_DELAY) begin
      if (cnt_r == 7'(FTRD_DOFS_POL)) begin
        pol_tmp_r <= db; // [R21]
      end
      if (cnt_r >= 7'(FTRD_DOFS_DBL) && cnt_r <= 7'(FTRD_DOFS_END)) begin
        dly_tmp_r <= {dly_tmp_r[55:0], db}; // [R21] [R24]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // commit on good frames; either requested or periodic reports [R3]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      week_r <= 16'h0000;
      tow_r <= 32'h0;
      lat_r <= 32'h0;
      lon_r <= 32'h0;
      alt_r <= 32'h0;
      ve_r <= 32'h0;
      vn_r <= 32'h0;
      vu_r <= 32'h0;
      stat_r <= 8'h00;
      hlth_r <= 8'h00;
      range_err_r <= 8'h00;
      for (int i = 0; i < FTRD_NUM_CHAN; i++) begin
        chan_r[i] <= 32'h0;
      end
    end else if (fix_ok && ctrl_r[0]) begin
      week_r <= week_tmp_r;
      tow_r <= tmp_r[0];
      lat_r <= tmp_r[1];
      lon_r <= tmp_r[2];
      alt_r <= tmp_r[3];
      ve_r <= tmp_r[4];
      vn_r <= tmp_r[5];
      vu_r <= tmp_r[6];
      stat_r <= stat_tmp_r;
      hlth_r <= hlth_tmp_r;
      range_err_r <= rerr_tmp_r;
      chan_r <= chan_tmp_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pol_r <= 8'h00;
      dly_r <= 64'h0; // default offset is zero
    end else if (dly_ok && ctrl_r[0]) begin
      pol_r <= pol_tmp_r;
      dly_r <= dly_tmp_r;
    end
  end

  // width report armed by the command; arrival wins over new arming
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      width_arm_r <= 1'b0;
      width_cnt_r <= 8'h00;
    end else if (wid_ok) begin
      width_arm_r <= 1'b0; // [R22]
      width_cnt_r <= width_cnt_r + 8'h01;
    end else if (width_cmd_sent) begin
      width_arm_r <= 1'b1;
    end
  end

  // counters and event outputs
  // the pulses leave from flops in step with the register commit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fix_cnt_r <= 8'h00;
      dly_cnt_r <= 8'h00;
      fix_done <= 1'b0;
      frame_err <= 1'b0;
    end else begin
      fix_done <= fix_ok && ctrl_r[0];
      frame_err <= eof && is_rpt_r && !fix_ok && !dly_ok && !wid_ok;
      if (fix_ok && ctrl_r[0]) fix_cnt_r <= fix_cnt_r + 8'h01;
      if (dly_ok && ctrl_r[0]) dly_cnt_r <= dly_cnt_r + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave, zero wait states; unmapped reads zero with pslverr
  // decoding at setup lets data stand with pready in the access cycle;
  // the price is a flop stage on prdata for every word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= FTRD_CTRL_RST;
    end else if (psel && penable && pwrite && paddr == FTRD_A_CTRL) begin
      ctrl_r <= {31'h0, pwdata[0]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      if (psel && !penable) begin
        if (paddr >= FTRD_A_CHAN
            && paddr < FTRD_A_CHAN + 8'(4 * FTRD_NUM_CHAN)) begin
          if (!pwrite) prdata <= chan_r[4'(paddr[5:2])]; // [R18] [R19]
          else pslverr <= 1'b1;
        end else if (pwrite) begin
          pslverr <= (paddr != FTRD_A_CTRL);
        end else begin
          case (paddr)
            FTRD_A_CTRL: prdata <= ctrl_r;
            FTRD_A_STATUS: prdata <= {range_err_r, width_cnt_r,
              dly_cnt_r, fix_cnt_r};
            FTRD_A_WEEK: prdata <= {7'h00, width_arm_r, pol_r, week_r};
            FTRD_A_TOW: prdata <= tow_r;
            FTRD_A_LAT: prdata <= lat_r;
            FTRD_A_LON: prdata <= lon_r;
            FTRD_A_ALT: prdata <= alt_r;
            FTRD_A_VE: prdata <= ve_r;
            FTRD_A_VN: prdata <= vn_r;
            FTRD_A_VU: prdata <= vu_r;
            // bits 2,3 masked unless status is zero [R14]
            FTRD_A_FIXST: prdata <= {15'h0,
              (stat_r >= FTRD_ST_SV0 && stat_r <= FTRD_ST_SV3), // [R12]
              hlth_r[7:4], // [R15]
              hlth_r[FTRD_H_CORR] && stat_r == FTRD_ST_FIXING,
              hlth_r[FTRD_H_2D] && stat_r == FTRD_ST_FIXING,
              hlth_r[FTRD_H_SHORT] && hlth_r[FTRD_H_ANT], // [R13]
              hlth_r[FTRD_H_ANT], stat_r};
            FTRD_A_DLYLO: prdata <= dly_r[31:0];
            FTRD_A_DLYHI: prdata <= dly_r[63:32];
            default: pslverr <= 1'b1;
          endcase
        end
      end
    end
  end
endmodule : ftrd_top

// ### sim/ftrd_rx_model.sv
`timescale 1ns/1ps
// far-end report source: frames, stuffs and paces link bytes
module ftrd_rx_model
  import ftrd_pkg::*;
(
  input wire logic pclk,
  output logic rx_valid,
  output logic [7:0] rx_byte
);
  logic [7:0] q[$];
  int slow = 0;
  // idle line shows the inverse of the last byte, never a stale copy
  initial begin
    rx_valid = 1'b0;
    rx_byte = 8'hFF;
  end
  //////////////////////////////////////////////////////////////
  // one byte per edge; gaps only when pacing is slow
  task automatic put(input logic [7:0] b);
    rx_valid <= 1'b1;
    rx_byte <= b;
    @(posedge pclk);
    if (slow > 0) begin
      rx_valid <= 1'b0;
      rx_byte <= ~b;
      repeat (slow) @(posedge pclk);
    end
  endtask : put
  // header, stuffed data, trailer; queue is emptied afterwards
  task automatic frame(input logic [7:0] id);
    put(FTRD_ESC);
    put(id);
    foreach (q[i]) begin
      put(q[i]);
      if (q[i] == FTRD_ESC) put(FTRD_ESC);
    end
    put(FTRD_ESC);
    // end byte goes out with no trailing gap, so the caller's answer
    // window opens at the edge that takes it
    rx_valid <= 1'b1;
    rx_byte <= FTRD_EOT;
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_byte <= ~FTRD_EOT;
    q.delete();
  endtask : frame
endmodule : ftrd_rx_model

// ### sim/ftrd_chk.sv
`timescale 1ns/1ps
// port-level checks on the bus slave and the report parser
module ftrd_chk
  import ftrd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic width_cmd_sent,
  input wire logic fix_done,
  input wire logic frame_err
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic mapped;
  logic eot;
  // gap at 0x34..0x3C and above the last channel word is unmapped
  assign mapped = paddr[1:0] == 2'b00 && (paddr <= FTRD_A_DLYHI ||
    (paddr >= FTRD_A_CHAN && paddr < 8'h70));
  assign eot = rx_valid && rx_byte == FTRD_EOT;
  sequence setup_s;
    psel && !penable;
  endsequence
  //////////////////////////////////////////////////////////////
  apb_answer_a: assert property (setup_s |=> pready)
    else $error("no answer after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  ready_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  write_refuse_a: assert property (setup_s ##0
    (pwrite && paddr != FTRD_A_CTRL) |=> pslverr)
    else $error("write to read-only word accepted");
  unmapped_read_a: assert property (setup_s ##0 (!pwrite && !mapped)
    |=> pslverr && prdata == 32'h0)
    else $error("unmapped read not refused");
  mapped_ok_a: assert property (setup_s ##0
    (mapped && (!pwrite || paddr == FTRD_A_CTRL)) |=> !pslverr)
    else $error("legal access refused");
  done_latency_a: assert property (fix_done |-> $past(eot, 2))
    else $error("done not two cycles after end byte");
  err_latency_a: assert property (frame_err |-> $past(eot, 2))
    else $error("frame error not two cycles after end byte");
  done_pulse_a: assert property (fix_done |=> !fix_done)
    else $error("done longer than one cycle");
  done_excl_a: assert property (!(fix_done && frame_err))
    else $error("done and error together");
endmodule : ftrd_chk
bind ftrd_top ftrd_chk chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .rx_valid, .rx_byte,
  .width_cmd_sent, .fix_done, .frame_err);

// ### sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  import ftrd_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic width_cmd_sent = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, rx_valid, fix_done, frame_err;
  logic [7:0] rx_byte;
  logic [31:0] lfsr = 32'h74D2506A;
  logic [31:0] rd, v;
  logic err;
  logic [1:0] seen;
  logic [15:0] wk;
  logic [31:0] ex [0:27];
  logic [31:0] old [0:27];
  logic [7:0] codes [0:7] = '{8'h00, 8'h01, 8'h03, 8'h08, 8'h09, 8'h0A,
    8'h0B, 8'hBB};
  int fail_count = 0;
  int samples_checked = 0;
  int lr, le;
  always #5 pclk = ~pclk;
  ftrd_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .rx_valid, .rx_byte,
    .width_cmd_sent, .fix_done, .frame_err);
  ftrd_rx_model src (.pclk, .rx_valid, .rx_byte);
  //////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd
  // host side: raw semicircles to radians, longitude wrapped into +-pi
  function automatic real to_rad(input logic [31:0] raw, input bit wrap);
    real r;
    if (wrap) r = real'(raw);
    else r = real'($signed(raw));
    r = r * 3.1415926535898 / 2.0 ** 31;
    if (wrap && r > 3.1415926535898) r = r - 2.0 * 3.1415926535898;
    return r;
  endfunction : to_rad
  task automatic end_sim();
    if (fail_count == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim
  task automatic check(input logic [31:0] got, exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : check
  // bus cycle; idle edge after release so psel never toggles twice
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      fail_count++;
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // fields go out most significant byte first
  task automatic p8(input logic [7:0] b);
    src.q.push_back(b);
  endtask : p8
  task automatic p32(input logic [31:0] w);
    for (int i = 3; i >= 0; i--) p8(w[8*i +: 8]);
  endtask : p32
  task automatic cmp_all();
    for (int i = 0; i < 28; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      check(rd, ex[i], "register");
    end
  endtask : cmp_all
  // send queued frame, then collect both pulses over a fixed window
  task automatic go();
    src.frame(FTRD_ID_REPORT);
    seen = 2'b00;
    repeat (8) begin
      @(posedge pclk);
      seen = seen | {frame_err, fix_done};
    end
  endtask : go
  // builds a fix report and the register image it should leave
  task automatic send_fix(input logic [7:0] st, sub, input logic [15:0] w);
    logic [7:0] h;
    h = 8'(rnd());
    p8(sub);
    p8(FTRD_RSVD_VAL);
    p8(FTRD_RSVD_VAL);
    p8(w[15:8]);
    p8(w[7:0]);
    ex[2][15:0] = w;
    for (int i = 3; i <= 9; i++) begin
      v = rnd();
      if (i == 3) v = v % 32'd604800000;
      if (i == 4) v[7:0] = FTRD_ESC;
      ex[i] = v;
      p32(v);
    end
    p8(st);
    p8(h);
    p8(FTRD_RSVD_VAL);
    ex[10] = {15'h0, st >= FTRD_ST_SV0 && st <= FTRD_ST_SV3, h[7:4],
      h[3] & (st == 8'h00), h[2] & (st == 8'h00), h[1] & h[0], h[0], st};
    for (int n = 0; n < FTRD_NUM_CHAN; n++) begin
      v = rnd();
      v[31:24] = n[0] ? 8'h78 + 8'(n) : 8'h01 + 8'(n);
      if (n == 10) v[31:24] = FTRD_SV_GPS_MAX;
      if (n == 11) v[31:24] = FTRD_SV_SBAS_MAX;
      v[23:16] = v[23:16] % 8'h38;
      ex[16 + n] = v;
      p32(v);
    end
  endtask : send_fix
  //////////////////////////////////////////////////////////////
  initial begin
    foreach (ex[i]) ex[i] = 32'h0;
    ex[0] = FTRD_CTRL_RST;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    cmp_all();
    // refusals on the bus, then an accepted ctrl write
    apb(1'b1, FTRD_A_WEEK, 32'hFFFFFFFF);
    check(32'(err), 32'h1, "write refused");
    apb(1'b0, FTRD_A_WEEK, 32'h0);
    check(rd, 32'h0, "refused write had effect");
    apb(1'b0, 8'h38, 32'h0);
    check(32'(err), 32'h1, "unmapped read");
    apb(1'b1, FTRD_A_CTRL, 32'h1);
    check(32'(err), 32'h0, "ctrl write");
    // every status code, week 16 and the 1023 edge, random link pacing
    for (int k = 0; k < 8; k++) begin
      src.slow = rnd() % 3;
      wk = k == 0 ? 16'h0010 : k == 1 ? FTRD_WEEK_MAX : 16'(rnd() % 1024);
      send_fix(codes[k], FTRD_SUB_FIX, wk);
      ex[1][7:0] = ex[1][7:0] + 8'h01;
      go();
      check(32'(seen), 32'h1, "fix pulse");
      cmp_all();
      apb(1'b0, FTRD_A_LON, 32'h0);
      lr = $rtoi(to_rad(rd, 1'b1) * 1.0E6);
      le = $rtoi(to_rad(ex[5], 1'b0) * 1.0E6);
      check(32'(lr), 32'(le), "longitude in radians");
    end
    // wrong sub-code and a short frame commit nothing
    old = ex;
    send_fix(8'h00, 8'h2C, 16'h0001);
    ex = old;
    go();
    check(32'(seen), 32'h2, "bad sub-code");
    p8(FTRD_SUB_FIX);
    repeat (9) p8(8'h00);
    go();
    check(32'(seen), 32'h2, "short frame");
    cmp_all();
    // delay response: polarity and the offset double
    p8(FTRD_SUB_DELAY);
    p8(8'h00);
    p8(8'h00);
    p8(8'h01);
    v = rnd();
    v[31:24] = FTRD_ESC;
    p32(v);
    ex[12] = v;
    v = rnd();
    p32(v);
    ex[11] = v;
    p32(32'h0);
    ex[2][23:16] = 8'h01;
    ex[1][15:8] = 8'h01;
    go();
    check(32'(seen), 32'h0, "delay frame");
    cmp_all();
    // commit switched off: a good frame leaves every register alone
    apb(1'b1, FTRD_A_CTRL, 32'h0);
    old = ex;
    send_fix(8'h00, FTRD_SUB_FIX, 16'h0002);
    ex = old;
    ex[0] = 32'h0;
    go();
    check(32'(seen), 32'h0, "commit disabled");
    cmp_all();
    apb(1'b1, FTRD_A_CTRL, 32'h1);
    ex[0] = FTRD_CTRL_RST;
    // width report is refused until the command arms it
    p8(FTRD_SUB_WIDTH);
    p8(8'h00);
    go();
    check(32'(seen), 32'h2, "unarmed width");
    width_cmd_sent <= 1'b1;
    @(posedge pclk);
    width_cmd_sent <= 1'b0;
    @(posedge pclk);
    apb(1'b0, FTRD_A_WEEK, 32'h0);
    check(32'(rd[24]), 32'h1, "arm set");
    p8(FTRD_SUB_WIDTH);
    p8(8'h00);
    go();
    check(32'(seen), 32'h0, "armed width");
    apb(1'b0, FTRD_A_WEEK, 32'h0);
    check(32'(rd[24]), 32'h0, "arm cleared");
    // week above 1023 is flagged but still committed
    send_fix(8'h00, FTRD_SUB_FIX, 16'h0400);
    go();
    check(32'(seen), 32'h1, "range frame");
    apb(1'b0, FTRD_A_STATUS, 32'h0);
    check(32'(rd[24]), 32'h1, "week range flag");
    check(32'(rd[23:16]), 32'h1, "width count");
    apb(1'b0, FTRD_A_WEEK, 32'h0);
    check(32'(rd[15:0]), 32'h400, "week kept");
    end_sim();
  end
endmodule : testbench
